// *** common/serial_format_pkg.sv ***
// Serial format register block: offsets, field positions, reset values,
// and lookup figures shared by the block and its bench.
// Assumes a byte-addressed classic Wishbone slave with 32-bit data.
package serial_format_pkg;

  // Register byte offsets on the bus
  localparam logic [3:0] FORMAT_OFS = 4'h0;
  localparam logic [3:0] CARD_OFS = 4'h4;
  localparam logic [3:0] STATUS_OFS = 4'h8;
  localparam logic [3:0] TXDATA_OFS = 4'hc;

  // Field positions of serial_format_register
  localparam int COMM_MODE_BIT = 7;
  localparam int EXT_TIMING_BIT = 7;
  localparam int BLOCK_BIT = 6;
  localparam int PARITY_EN_BIT = 5;
  localparam int PARITY_ODD_BIT = 4;
  localparam int CPB_HI_BIT = 3;
  localparam int CPB_LO_BIT = 2;
  localparam int MP_BIT = 2;
  localparam int PRESC_HI_BIT = 1;
  localparam int PRESC_LO_BIT = 0;

  // Field positions of card_mode_register and of the status register
  localparam int CARD_SEL_BIT = 0;
  localparam int ST_PAR_ERR_BIT = 0;
  localparam int ST_ASYNC_BIT = 1;
  localparam int ST_MP_BIT = 2;
  localparam int ST_PARITY_BIT = 3;
  localparam int ST_CARD_BIT = 4;
  localparam int ST_TX_FULL_BIT = 5;

  // Reset values
  localparam logic [7:0] FORMAT_RST = 8'h00;
  localparam logic CARD_RST = 1'b0;

  // Prescaler divisions for select 00..11
  localparam logic [6:0] PRESC_DIV0 = 7'h01;
  localparam logic [6:0] PRESC_DIV1 = 7'h04;
  localparam logic [6:0] PRESC_DIV2 = 7'h10;
  localparam logic [6:0] PRESC_DIV3 = 7'h40;

  // Basic clocks per bit for card field 00..11
  localparam logic [8:0] CPB_VAL0 = 9'd32;
  localparam logic [8:0] CPB_VAL1 = 9'd64;
  localparam logic [8:0] CPB_VAL2 = 9'd372;
  localparam logic [8:0] CPB_VAL3 = 9'd256;

  // Early finish of transmission in extended card timing, whole etu
  localparam logic [3:0] LEAD_ETU = 4'd11;

  // Transmit buffer shape
  localparam int TX_DATA_W = 8;
  localparam int TX_DEPTH = 8;

endpackage

// *** design/serial_format_mode.sv ***
// Mode register of a serial channel: format decode, prescaler, parity.
// Assumes a classic Wishbone master on clk_i and a character sink and
// receive checker fed from logic on the same clock.
//
// The implementer's own choices: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps

// Function
// - Multiprocessor bit 2 enables multiprocessor operation only in async normal mode (card select 0).
// - While multiprocessor mode is active, parity is neither added nor checked.
// - Prescaler select 00/01/10/11 divides the clock by 1/4/16/64.
// - The prescaler select value 0..3 is reported as the exponent index n.
// - Extended card timing (bit 7) finishes transmission 11.0 etu earlier.
// - Extended card timing also makes extra card clock control modes available.
// - In card mode bit 6 selects block transfer instead of per character.
// - With parity enabled in async mode a parity bit is added on send and checked on receive.
// - Parity sense bit 4 picks even (0) or odd (1) only when parity is active.
// - In card mode the clocks-per-bit field gives 32, 64, 372 or 256 clocks.
// - The card interface select bit picks normal or card field meanings.
// - In normal mode bit 7 picks async (0) or clocked synchronous (1).
module serial_format_mode
  import serial_format_pkg::*;
#(
  parameter int FIFO_DEPTH = TX_DEPTH
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic [8:0] frame_data_o,
  output logic frame_has_parity_o,
  output logic frame_valid_o,
  input wire logic frame_ready_i,
  input wire logic [7:0] rx_char_i,
  input wire logic rx_parity_i,
  input wire logic rx_valid_i,
  output logic parity_error_o,
  output logic prescale_tick_o,
  output logic [1:0] prescale_exp_o,
  output logic async_mode_o,
  output logic multiproc_active_o,
  output logic parity_active_o,
  output logic parity_odd_o,
  output logic block_mode_o,
  output logic extended_timing_o,
  output logic [3:0] finish_lead_etu_o,
  output logic card_clock_ctrl_avail_o,
  output logic [8:0] card_clocks_per_bit_o
);

  typedef struct packed {
    logic [7:0] fmt;
    logic card_sel;
    logic ack;
    logic [7:0] rdat;
    logic [6:0] pre_cnt;
    logic pre_tick;
    logic [1:0] presc_n;
    logic frame_valid;
    logic [8:0] frame_data;
    logic frame_par;
    logic par_err;
    logic par_err_sticky;
    logic async_mode;
    logic mp_active;
    logic par_active;
    logic par_odd;
    logic block_mode;
    logic ext_timing;
    logic [3:0] lead_etu;
    logic clk_ctrl_avail;
    logic [8:0] cpb;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  logic fifo_in_ready;
  logic [7:0] fifo_out_data;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic fifo_push;

  logic req;
  logic wr_commit;
  logic hit_fmt;
  logic hit_card;
  logic hit_status;
  logic hit_tx;
  logic [6:0] pre_div;

  assign req = cyc_i && stb_i;
  // Writes land on the edge where the master sees ack high
  assign wr_commit = req && we_i && st_r.ack && sel_i[0];

  always_comb begin
    hit_fmt = 1'b0;
    hit_card = 1'b0;
    hit_status = 1'b0;
    hit_tx = 1'b0;
    if (adr_i == FORMAT_OFS) begin
      hit_fmt = 1'b1;
    end else if (adr_i == CARD_OFS) begin
      hit_card = 1'b1;
    end else if (adr_i == STATUS_OFS) begin
      hit_status = 1'b1;
    end else if (adr_i == TXDATA_OFS) begin
      hit_tx = 1'b1;
    end
  end

  always_comb begin
    case (st_r.presc_n)
      2'b00: pre_div = PRESC_DIV0;
      2'b01: pre_div = PRESC_DIV1;
      2'b10: pre_div = PRESC_DIV2;
      default: pre_div = PRESC_DIV3;
    endcase
  end

  assign fifo_push = wr_commit && hit_tx;
  assign fifo_out_ready = !st_r.frame_valid || frame_ready_i;

  tx_char_fifo #(
    .WIDTH(TX_DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_tx_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_data_i(dat_i[7:0]),
    .in_valid_i(fifo_push),
    .in_ready_o(fifo_in_ready),
    .out_data_o(fifo_out_data),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_out_ready)
  );

  always_comb begin
    st_nxt = st_r;

    // Bus slave; a full buffer holds off ack so the master stalls
    st_nxt.ack = req && !st_r.ack && !(we_i && hit_tx && !fifo_in_ready);
    st_nxt.rdat = 8'h00;
    if (hit_fmt) begin
      st_nxt.rdat = st_r.fmt;
    end else if (hit_card) begin
      st_nxt.rdat[CARD_SEL_BIT] = st_r.card_sel;
    end else if (hit_status) begin
      st_nxt.rdat[ST_PAR_ERR_BIT] = st_r.par_err_sticky;
      st_nxt.rdat[ST_ASYNC_BIT] = st_r.async_mode;
      st_nxt.rdat[ST_MP_BIT] = st_r.mp_active;
      st_nxt.rdat[ST_PARITY_BIT] = st_r.par_active;
      st_nxt.rdat[ST_CARD_BIT] = st_r.card_sel;
      st_nxt.rdat[ST_TX_FULL_BIT] = !fifo_in_ready;
    end
    if (wr_commit && hit_fmt) begin
      st_nxt.fmt = dat_i[7:0];
    end
    if (wr_commit && hit_card) begin
      st_nxt.card_sel = dat_i[CARD_SEL_BIT];
    end

    // Field decode, one cycle behind the register
    if (st_r.card_sel) begin
      st_nxt.async_mode = 1'b1;
      st_nxt.mp_active = 1'b0;
      st_nxt.block_mode = st_r.fmt[BLOCK_BIT];
      st_nxt.ext_timing = st_r.fmt[EXT_TIMING_BIT];
      st_nxt.clk_ctrl_avail = st_r.fmt[EXT_TIMING_BIT];
      st_nxt.lead_etu = st_r.fmt[EXT_TIMING_BIT] ? LEAD_ETU : 4'h0;
      case (st_r.fmt[CPB_HI_BIT:CPB_LO_BIT])
        2'b00: st_nxt.cpb = CPB_VAL0;
        2'b01: st_nxt.cpb = CPB_VAL1;
        2'b10: st_nxt.cpb = CPB_VAL2;
        default: st_nxt.cpb = CPB_VAL3;
      endcase
    end else begin
      st_nxt.async_mode = !st_r.fmt[COMM_MODE_BIT];
      st_nxt.mp_active = st_r.fmt[MP_BIT] && !st_r.fmt[COMM_MODE_BIT];
      st_nxt.block_mode = 1'b0;
      st_nxt.ext_timing = 1'b0;
      st_nxt.clk_ctrl_avail = 1'b0;
      st_nxt.lead_etu = 4'h0;
      st_nxt.cpb = CPB_VAL0;
    end
    // Card mode is async by nature; multiprocessor kills parity
    st_nxt.par_active = st_r.fmt[PARITY_EN_BIT] && st_nxt.async_mode
                        && !st_nxt.mp_active;
    st_nxt.par_odd = st_r.fmt[PARITY_ODD_BIT];
    st_nxt.presc_n = st_r.fmt[PRESC_HI_BIT:PRESC_LO_BIT];

    // Prescaler; >= guards a shrink of the division mid count
    if (st_r.pre_cnt >= pre_div - 7'h01) begin
      st_nxt.pre_cnt = 7'h00;
      st_nxt.pre_tick = 1'b1;
    end else begin
      st_nxt.pre_cnt = st_r.pre_cnt + 7'h01;
      st_nxt.pre_tick = 1'b0;
    end

    // Character framing with parity taken from the active setting
    if (fifo_out_ready) begin
      st_nxt.frame_valid = fifo_out_valid;
      if (fifo_out_valid) begin
        st_nxt.frame_par = st_r.par_active;
        st_nxt.frame_data = {^fifo_out_data ^ st_r.par_odd,
                             fifo_out_data};
        if (!st_r.par_active) begin
          st_nxt.frame_data[8] = 1'b0;
        end
      end
    end

    // Receive check; a new error wins over a clear in the same cycle
    st_nxt.par_err = rx_valid_i && st_r.par_active
                     && ((^{rx_char_i, rx_parity_i}) != st_r.par_odd);
    if (wr_commit && hit_status && dat_i[ST_PAR_ERR_BIT]) begin
      st_nxt.par_err_sticky = 1'b0;
    end
    if (st_nxt.par_err) begin
      st_nxt.par_err_sticky = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '0;
      st_r.fmt <= FORMAT_RST;
      st_r.card_sel <= CARD_RST;
      st_r.async_mode <= 1'b1;
      st_r.cpb <= CPB_VAL0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign dat_o = {24'h000000, st_r.rdat};
  assign ack_o = st_r.ack;
  assign frame_data_o = st_r.frame_data;
  assign frame_has_parity_o = st_r.frame_par;
  assign frame_valid_o = st_r.frame_valid;
  assign parity_error_o = st_r.par_err;
  assign prescale_tick_o = st_r.pre_tick;
  assign prescale_exp_o = st_r.presc_n;
  assign async_mode_o = st_r.async_mode;
  assign multiproc_active_o = st_r.mp_active;
  assign parity_active_o = st_r.par_active;
  assign parity_odd_o = st_r.par_odd;
  assign block_mode_o = st_r.block_mode;
  assign extended_timing_o = st_r.ext_timing;
  assign finish_lead_etu_o = st_r.lead_etu;
  assign card_clock_ctrl_avail_o = st_r.clk_ctrl_avail;
  assign card_clocks_per_bit_o = st_r.cpb;

  a_mp_no_parity: assert property (@(posedge clk_i) disable iff (rst_i)
    st_r.mp_active |-> !st_r.par_active && !($rose(st_r.frame_valid)
    && $past(st_r.mp_active) && st_r.frame_par))
    else $error("parity active during multiprocessor mode");

  a_mp_async_only: assert property (@(posedge clk_i) disable iff (rst_i)
    st_r.mp_active |-> st_r.async_mode && !$past(st_r.card_sel))
    else $error("multiprocessor mode outside async normal mode");

  a_presc_by_four: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_r.pre_tick && st_r.presc_n == 2'b01 && st_r.fmt[1:0] == 2'b01)
    |=> !st_r.pre_tick[*3] ##1 st_r.pre_tick)
    else $error("prescaler divide by four period wrong");

  a_presc_exp_idx: assert property (@(posedge clk_i) disable iff (rst_i)
    st_r.presc_n == $past(st_r.fmt[1:0]))
    else $error("prescaler exponent does not follow select");

  a_lead_eleven: assert property (@(posedge clk_i) disable iff (rst_i)
    st_r.ext_timing |-> st_r.lead_etu == 4'd11 && st_r.clk_ctrl_avail)
    else $error("extended timing lead or clock control wrong");

  a_block_follow: assert property (@(posedge clk_i) disable iff (rst_i)
    st_r.block_mode == ($past(st_r.card_sel) && $past(st_r.fmt[6])))
    else $error("block mode does not follow card setting");

  a_rx_parity_chk: assert property (@(posedge clk_i) disable iff (rst_i)
    (rx_valid_i && st_r.par_active
     && ((^{rx_char_i, rx_parity_i}) != st_r.par_odd))
    |=> st_r.par_err ##1 st_r.par_err_sticky)
    else $error("receive parity error not flagged");

  a_cpb_card_372: assert property (@(posedge clk_i) disable iff (rst_i)
    ($past(st_r.card_sel) && $past(st_r.fmt[3:2]) == 2'b10)
    |-> st_r.cpb == 9'd372)
    else $error("clocks per bit not 372");

  a_async_select: assert property (@(posedge clk_i) disable iff (rst_i)
    !$past(st_r.card_sel) |-> st_r.async_mode == !$past(st_r.fmt[7]))
    else $error("communication mode decode wrong");

  a_ack_one_shot: assert property (@(posedge clk_i) disable iff (rst_i)
    st_r.ack |=> !st_r.ack)
    else $error("ack held for two cycles");

  a_tx_par_bit: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_r.frame_valid && st_r.frame_par)
    |-> (^st_r.frame_data) == $past(st_r.par_odd, 1) || $past(st_r.frame_valid))
    else $error("transmit parity bit has wrong sense");

endmodule // serial_format_mode

// *** design/tx_char_fifo.sv ***
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module tx_char_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_r;
  logic [AW-1:0] rd_r;
  logic [AW:0] cnt_r;
  logic push;
  logic pop;

  assign in_ready_o = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_r != '0);
  assign out_data_o = mem_r[rd_r];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_r[wr_r] <= in_data_i;
    end
    if (rst_i) begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wr_r <= (wr_r == AW'(DEPTH - 1)) ? '0 : wr_r + 1'b1;
      end
      if (pop) begin
        rd_r <= (rd_r == AW'(DEPTH - 1)) ? '0 : rd_r + 1'b1;
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // tx_char_fifo

// *** tb/serial_far_end.sv ***
// Far end of the character link: frame sink and receive source.
// Assumes the block's clock; the bench sets stall and calls send_rx.
`timescale 1ns/1ps
module serial_far_end (
  input wire logic clk_i,
  input wire logic [8:0] frame_data_i,
  input wire logic frame_has_parity_i,
  input wire logic frame_valid_i,
  output logic frame_ready_o,
  output logic [7:0] rx_char_o,
  output logic rx_parity_o,
  output logic rx_valid_o
);
  logic stall = 1'b0;
  logic [9:0] got[$];
  initial begin
    frame_ready_o = 1'b0;
    rx_char_o = 8'h00;
    rx_parity_o = 1'b0;
    rx_valid_o = 1'b0;
  end
  always @(posedge clk_i) begin
    if (frame_valid_i && frame_ready_o) begin
      got.push_back({frame_has_parity_i, frame_data_i});
    end
    frame_ready_o <= !stall;
  end
  task send_rx(input logic [7:0] c, input logic p);
    @(posedge clk_i);
    rx_char_o <= c;
    rx_parity_o <= p;
    rx_valid_o <= 1'b1;
    @(posedge clk_i);
    rx_valid_o <= 1'b0;
    // Stale lines flip so a lazy sampler cannot pass by luck
    rx_char_o <= ~c;
    rx_parity_o <= ~p;
  endtask
endmodule // serial_far_end

// *** tb/tb_top.sv ***
// Self-checking bench for the serial format register block.
// Assumes the far end model and the package of the block.
`timescale 1ns/1ps
module tb_top;
  import serial_format_pkg::*;
  logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, frame_has_parity_o;
  logic [3:0] adr_i, sel_i, finish_lead_etu_o;
  logic [31:0] dat_i, dat_o;
  logic [8:0] frame_data_o, card_clocks_per_bit_o;
  logic frame_valid_o, frame_ready_i, rx_parity_i, rx_valid_i;
  logic [7:0] rx_char_i;
  logic parity_error_o, prescale_tick_o, async_mode_o, multiproc_active_o;
  logic [1:0] prescale_exp_o;
  logic parity_active_o, parity_odd_o, block_mode_o, extended_timing_o;
  logic card_clock_ctrl_avail_o;
  int fail_count = 0;
  int comparisons = 0;

  serial_format_mode dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
    .sel_i, .dat_i, .dat_o, .ack_o, .frame_data_o, .frame_has_parity_o,
    .frame_valid_o, .frame_ready_i, .rx_char_i, .rx_parity_i, .rx_valid_i,
    .parity_error_o, .prescale_tick_o, .prescale_exp_o, .async_mode_o,
    .multiproc_active_o, .parity_active_o, .parity_odd_o, .block_mode_o,
    .extended_timing_o, .finish_lead_etu_o, .card_clock_ctrl_avail_o,
    .card_clocks_per_bit_o);
  serial_far_end far (.clk_i(clk_i), .frame_data_i(frame_data_o),
    .frame_has_parity_i(frame_has_parity_o), .frame_valid_i(frame_valid_o),
    .frame_ready_o(frame_ready_i), .rx_char_o(rx_char_i),
    .rx_parity_o(rx_parity_i), .rx_valid_o(rx_valid_i));

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  task stop_test;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task wb(input logic w, input logic [3:0] a, input logic [7:0] d,
          output logic [7:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= {24'h000000, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 500);
    if (n >= 500) chk("ack", 1, 0);
    q = dat_o[7:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask

  task wr(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] q;
    wb(1'b1, a, d, q);
  endtask

  task rdchk(input string nm, input logic [3:0] a, input logic [7:0] e);
    logic [7:0] q;
    wb(1'b0, a, 8'h00, q);
    chk(nm, e, q);
  endtask

  // Decoded outputs trail the ack edge by one cycle
  task settle;
    repeat (3) @(posedge clk_i);
  endtask

  task wait_tick(output int n);
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (prescale_tick_o !== 1'b1 && n < 100);
  endtask

  task expect_frame(input logic [9:0] e);
    int n;
    n = 0;
    while (far.got.size() == 0 && n < 100) begin
      @(posedge clk_i);
      n++;
    end
    if (far.got.size() == 0) chk("frame missing", 1, 0);
    else chk("frame", e, far.got.pop_front());
  endtask

  task t_reset;
    rdchk("format reset", FORMAT_OFS, 8'h00);
    rdchk("card reset", CARD_OFS, 8'h00);
    chk("async reset", 1, async_mode_o);
    chk("cpb reset", 32, card_clocks_per_bit_o);
    wr(FORMAT_OFS, 8'h5a);
    rdchk("format rw", FORMAT_OFS, 8'h5a);
    wr(4'h2, 8'hff);
    rdchk("unmapped", 4'h2, 8'h00);
  endtask

  task t_presc;
    int n;
    for (int s = 0; s < 4; s++) begin
      wr(FORMAT_OFS, 8'(s));
      settle;
      chk("exp", s, prescale_exp_o);
      wait_tick(n);
      wait_tick(n);
      chk("tick gap", 1 << (2 * s), n);
    end
  endtask

  task t_mp;
    wr(FORMAT_OFS, 8'h34);
    settle;
    chk("mp on", 1, multiproc_active_o);
    chk("parity off", 0, parity_active_o);
    wr(TXDATA_OFS, 8'h5b);
    expect_frame(10'h05b);
    wr(FORMAT_OFS, 8'ha4);
    settle;
    chk("mp sync", 0, multiproc_active_o);
    chk("sync mode", 0, async_mode_o);
  endtask

  task t_fifo;
    logic [7:0] q;
    logic [7:0] d;
    int k;
    // Sink stalls first, so the buffer has to fill until it reports full
    far.stall = 1'b1;
    wr(FORMAT_OFS, 8'h30);
    k = 0;
    do begin
      wr(TXDATA_OFS, 8'h3c + 8'(k));
      wb(1'b0, STATUS_OFS, 8'h00, q);
      k++;
    end while (q[ST_TX_FULL_BIT] !== 1'b1 && k < 12);
    chk("filled", 1, k >= TX_DEPTH);
    far.stall = 1'b0;
    for (int i = 0; i < k; i++) begin
      d = 8'h3c + 8'(i);
      expect_frame({1'b1, ~^d, d});
    end
    rdchk("drained", STATUS_OFS, 8'h0a);
    wr(FORMAT_OFS, 8'h20);
    wr(TXDATA_OFS, 8'h81);
    expect_frame({2'b10, 8'h81});
  endtask

  task t_rx;
    wr(FORMAT_OFS, 8'h20);
    settle;
    chk("even sense", 0, parity_odd_o);
    far.send_rx(8'h07, 1'b1);
    @(posedge clk_i);
    chk("rx good", 0, parity_error_o);
    far.send_rx(8'h07, 1'b0);
    @(posedge clk_i);
    chk("rx bad", 1, parity_error_o);
    rdchk("sticky", STATUS_OFS, 8'h0b);
    wr(STATUS_OFS, 8'h01);
    rdchk("cleared", STATUS_OFS, 8'h0a);
    wr(FORMAT_OFS, 8'h30);
    settle;
    chk("odd sense", 1, parity_odd_o);
    far.send_rx(8'h07, 1'b0);
    @(posedge clk_i);
    chk("rx odd", 0, parity_error_o);
    wr(FORMAT_OFS, 8'h00);
    settle;
    far.send_rx(8'h07, 1'b0);
    @(posedge clk_i);
    chk("rx off", 0, parity_error_o);
  endtask

  task t_card;
    int cpb[4];
    cpb = '{32, 64, 372, 256};
    wr(CARD_OFS, 8'h01);
    for (int b = 0; b < 4; b++) begin
      wr(FORMAT_OFS, 8'he0 | 8'(b << 2));
      settle;
      chk("cpb", cpb[b], card_clocks_per_bit_o);
      chk("lead", 11, finish_lead_etu_o);
      chk("ext", 1, extended_timing_o);
      chk("clk ctrl", 1, card_clock_ctrl_avail_o);
      chk("block", 1, block_mode_o);
    end
    wr(FORMAT_OFS, 8'h2c);
    settle;
    chk("lead off", 0, finish_lead_etu_o);
    chk("ext off", 0, extended_timing_o);
    chk("clk ctrl off", 0, card_clock_ctrl_avail_o);
    chk("block off", 0, block_mode_o);
    chk("mp card", 0, multiproc_active_o);
    wr(CARD_OFS, 8'h00);
    settle;
    chk("cpb normal", 32, card_clocks_per_bit_o);
    chk("mp normal", 1, multiproc_active_o);
  endtask

  // Mid-run reset must clear every field written before it
  task t_rerst;
    wr(FORMAT_OFS, 8'hff);
    wr(CARD_OFS, 8'h01);
    settle;
    chk("ext before", 1, extended_timing_o);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rdchk("format rerst", FORMAT_OFS, 8'h00);
    rdchk("card rerst", CARD_OFS, 8'h00);
    chk("ext rerst", 0, extended_timing_o);
    chk("async rerst", 1, async_mode_o);
  endtask

  initial begin
    rst_i = 1'b1;
    cyc_i = 1'b0;
    stb_i = 1'b0;
    we_i = 1'b0;
    adr_i = 4'h0;
    sel_i = 4'hf;
    dat_i = 32'h00000000;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset;
    t_presc;
    t_mp;
    t_fifo;
    t_rx;
    t_card;
    t_rerst;
    stop_test;
  end

  // Whole run needs well under a thousand cycles; this leaves ample margin
  initial begin
    repeat (20000) @(posedge clk_i);
    fail_count++;
    stop_test;
  end
endmodule // tb_top
